// File: verilog/hbp_defs.svh
/*
  Constants of the host bus port: strap decoding, register offsets,
  field positions and reset values.
  Assumes inclusion by bare name from the package and the port module.
*/
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define HBP_DATA_W 16
`define HBP_ADDR_W 16

// ----------------------------------------------------------------
// strap decoding
// ----------------------------------------------------------------
`define HBP_MODE_GENERIC 3'h7
`define HBP_BS_SHARED 1'h1
`define HBP_BS_SPLIT 1'h0
`define HBP_ORDER_BIG 1'h1
`define HBP_POL_HIGH 1'h1

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define HBP_OFF_CTRL 32'h0000_0000
`define HBP_OFF_STATUS 32'h0000_0004
`define HBP_CTRL_PWR_BIT 0
`define HBP_CTRL_RST 1'h0
`define HBP_ST_MODE_LSB 0
`define HBP_ST_BS_BIT 3
`define HBP_ST_ORDER_BIT 4
`define HBP_ST_POL_BIT 5
`define HBP_ST_SHARED_BIT 6
`define HBP_ST_SPLIT_BIT 7
`define HBP_ST_BUSY_BIT 8
`define HBP_ST_WAIT_BIT 9

`endif

// File: verilog/hbp_pkg.sv
/*
  Types of the host bus port: pin bundle, configuration, core request,
  state codes and the module's state record.
  Assumes hbp_defs.svh is on the include path.
*/
`include "hbp_defs.svh"

package hbp_pkg;

  // ----------------------------------------------------------------
  // access sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_REQ = 3'h2,
    ST_DONE = 3'h4
  } hbp_state_t;

  // host pins as seen after the synchroniser
  typedef struct packed {
    logic hclk;
    logic selN;
    logic rdN;
    logic weN;
    logic bheN;
    logic rdWrN;
    logic bsN;
    logic [2:0] modeStraps;
    logic orderStrap;
    logic polStrap;
    logic [`HBP_ADDR_W-1:0] addr;
    logic [`HBP_DATA_W-1:0] data;
  } hbp_pins_t;

  // configuration captured at reset release
  typedef struct packed {
    logic [2:0] mode;
    logic bs;
    logic bigEndian;
    logic pwrHigh;
  } hbp_cfg_t;

  // request toward the core arbiter
  typedef struct packed {
    logic req;
    logic write;
    logic [`HBP_ADDR_W-1:0] addr;
    logic [`HBP_DATA_W-1:0] wdata;
    logic [1:0] be;
  } hbp_mem_req_t;

  // whole state of the port module
  typedef struct packed {
    hbp_pins_t sync1;
    hbp_pins_t sync2;
    logic hclkPrev;
    logic inReset;
    hbp_cfg_t cfg;
    hbp_state_t st;
    hbp_mem_req_t mem;
    logic [`HBP_DATA_W-1:0] dOut;
    logic dOe;
    logic waitN;
    logic waitOe;
    logic pwrOut;
    logic ctrlPwr;
    logic aValid;
    logic aWrite;
    logic aCtrl;
    logic [31:0] hrdata;
  } hbp_core_t;

endpackage

// File: verilog/hbp_host_port.sv
/*
  Sixteen-bit host bus slave port with strap-selected mode, byte order
  and panel power polarity, plus a small AHB-Lite control block.
  Assumes: host pins are asynchronous to clk; the host bus clock is far
  slower than clk; mem* handshake lives on clk; srst held >= 2 cycles.

*/
`include "hbp_defs.svh"

module hbp_host_port #(
  parameter int DATA_W = `HBP_DATA_W,
  parameter int ADDR_W = `HBP_ADDR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hostBusClock,
  input wire logic hostSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic highByteEnableN,
  input wire logic rdWrDirN,
  input wire logic busStatusStrapN,
  input wire logic [2:0] busModeStraps,
  input wire logic byteOrderStrap,
  input wire logic panelPowerPolarityStrap,
  input wire logic [ADDR_W-1:0] deviceLocationInputs,
  input wire logic [DATA_W-1:0] deviceDataIn,
  output logic [DATA_W-1:0] deviceDataOut,
  output logic deviceDataOe,
  output logic waitOutN,
  output logic waitOe,
  output logic panelPowerControl,
  output hbp_pkg::hbp_mem_req_t memReq,
  input wire logic memAck,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != `HBP_DATA_W || ADDR_W != `HBP_ADDR_W) begin : gBadWidth
    $error("hbp_host_port serves only 16-bit data and address");
  end

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  hbp_pkg::hbp_core_t q;
  hbp_pkg::hbp_core_t d;
  hbp_pkg::hbp_pins_t pinsNow;
  hbp_pkg::hbp_pins_t p;

  // swap byte lanes for big-endian hosts
  function automatic logic [15:0] orderFix(
    input logic big,
    input logic [15:0] v
  );
    return big ? {v[7:0], v[15:8]} : v;
  endfunction

  // gather raw pins for the synchroniser
  always_comb begin
    pinsNow.hclk = hostBusClock;
    pinsNow.selN = hostSelectN;
    pinsNow.rdN = readStrobeN;
    pinsNow.weN = writeStrobeN;
    pinsNow.bheN = highByteEnableN;
    pinsNow.rdWrN = rdWrDirN;
    pinsNow.bsN = busStatusStrapN;
    pinsNow.modeStraps = busModeStraps;
    pinsNow.orderStrap = byteOrderStrap;
    pinsNow.polStrap = panelPowerPolarityStrap;
    pinsNow.addr = deviceLocationInputs;
    pinsNow.data = deviceDataIn;
  end

  assign p = q.sync2;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic hEdge;
  logic shared;
  logic split;
  logic modeOk;
  logic sel;
  logic rdAct;
  logic wrAct;
  logic active;
  logic [1:0] laneBe;
  logic [31:0] statusWord;

  always_comb begin
    d = q;
    // ----------------------------------------------------------------
    // two-stage synchroniser, edge detect on second stage only
    // ----------------------------------------------------------------
    d.sync1 = pinsNow;
    d.sync2 = q.sync1;
    d.hclkPrev = q.sync2.hclk;
    d.inReset = 1'b0;
    hEdge = p.hclk & ~q.hclkPrev;

    // ----------------------------------------------------------------
    // mode decode from captured straps
    // ----------------------------------------------------------------
    shared = (q.cfg.mode == `HBP_MODE_GENERIC)
      && (q.cfg.bs == `HBP_BS_SHARED);
    split = (q.cfg.mode == `HBP_MODE_GENERIC)
      && (q.cfg.bs == `HBP_BS_SPLIT);
    modeOk = shared | split;
    sel = ~p.selN;

    // ----------------------------------------------------------------
    // pin functions follow the captured mode
    // ----------------------------------------------------------------
    if (shared) begin
      rdAct = ~p.rdN;
      wrAct = ~p.weN;
      laneBe = {~p.bheN, ~p.addr[0]};
    end else begin
      rdAct = ~p.rdN | ~p.rdWrN;
      wrAct = ~p.weN | ~p.bheN;
      if (wrAct) begin
        laneBe = {~p.bheN, ~p.weN};
      end else begin
        laneBe = {~p.rdWrN, ~p.rdN};
      end
    end
    active = modeOk & sel & (rdAct | wrAct);

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    case (q.st)
      hbp_pkg::ST_IDLE: begin
        // wait low as soon as a served access is seen, before the host edge
        d.waitN = ~active;
        if (hEdge && active) begin
          d.st = hbp_pkg::ST_REQ;
          d.waitN = 1'b0;
          d.mem.req = 1'b1;
          d.mem.write = wrAct;
          d.mem.addr = p.addr;
          d.mem.wdata = orderFix(q.cfg.bigEndian, p.data);
          d.mem.be = q.cfg.bigEndian ? {laneBe[0], laneBe[1]} : laneBe;
        end
      end
      hbp_pkg::ST_REQ: begin
        d.waitN = 1'b0;
        if (memAck) begin
          d.mem.req = 1'b0;
          d.waitN = 1'b1;
          d.st = hbp_pkg::ST_DONE;
          if (!q.mem.write) begin
            d.dOut = orderFix(q.cfg.bigEndian, memRdata);
          end
        end
      end
      hbp_pkg::ST_DONE: begin
        d.waitN = 1'b1;
        if (hEdge && !active) begin
          d.st = hbp_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = hbp_pkg::ST_IDLE;
        d.waitN = 1'b1;
        d.mem.req = 1'b0;
      end
    endcase

    // ----------------------------------------------------------------
    // pin drivers while selected
    // ----------------------------------------------------------------
    d.waitOe = sel & modeOk;
    d.dOe = (d.st == hbp_pkg::ST_DONE) & ~q.mem.write & sel & rdAct & modeOk;

    // ----------------------------------------------------------------
    // straps caught on the first cycle after reset release
    // ----------------------------------------------------------------
    if (q.inReset) begin
      d.cfg.mode = p.modeStraps;
      d.cfg.bs = p.bsN; // strap level, 1 = shared
      d.cfg.bigEndian = (p.orderStrap == `HBP_ORDER_BIG);
      d.cfg.pwrHigh = (p.polStrap == `HBP_POL_HIGH);
    end

    // ----------------------------------------------------------------
    // panel power output in captured polarity
    // ----------------------------------------------------------------
    d.pwrOut = q.cfg.pwrHigh ? q.ctrlPwr : ~q.ctrlPwr;

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    statusWord = 32'h0000_0000;
    statusWord[`HBP_ST_MODE_LSB +: 3] = q.cfg.mode;
    statusWord[`HBP_ST_BS_BIT] = q.cfg.bs;
    statusWord[`HBP_ST_ORDER_BIT] = q.cfg.bigEndian;
    statusWord[`HBP_ST_POL_BIT] = q.cfg.pwrHigh;
    statusWord[`HBP_ST_SHARED_BIT] = shared;
    statusWord[`HBP_ST_SPLIT_BIT] = split;
    statusWord[`HBP_ST_BUSY_BIT] = (q.st != hbp_pkg::ST_IDLE);
    statusWord[`HBP_ST_WAIT_BIT] = ~q.waitN;

    // ----------------------------------------------------------------
    // ahb-lite address phase
    // ----------------------------------------------------------------
    d.aValid = 1'b0;
    if (hsel && hready && htrans[1]) begin
      d.aValid = 1'b1;
      d.aWrite = hwrite;
      d.aCtrl = (haddr == `HBP_OFF_CTRL);
      d.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr == `HBP_OFF_CTRL) begin
          d.hrdata[`HBP_CTRL_PWR_BIT] = q.ctrlPwr;
        end else if (haddr == `HBP_OFF_STATUS) begin
          d.hrdata = statusWord;
        end
      end
    end

    // ----------------------------------------------------------------
    // ahb-lite data phase write
    // ----------------------------------------------------------------
    if (q.aValid && q.aWrite && q.aCtrl) begin
      d.ctrlPwr = hwdata[`HBP_CTRL_PWR_BIT];
    end

    // ----------------------------------------------------------------
    // synchronous reset, synchroniser and edge history keep sampling
    // ----------------------------------------------------------------
    if (srst) begin
      d.inReset = 1'b1;
      d.cfg = '0;
      d.st = hbp_pkg::ST_IDLE;
      d.mem = '0;
      d.dOut = 16'h0000;
      d.dOe = 1'b0;
      d.waitN = 1'b1;
      d.waitOe = 1'b0;
      d.pwrOut = 1'b1;
      d.ctrlPwr = `HBP_CTRL_RST;
      d.aValid = 1'b0;
      d.aWrite = 1'b0;
      d.aCtrl = 1'b0;
      d.hrdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign deviceDataOut = q.dOut;
  assign deviceDataOe = q.dOe;
  assign waitOutN = q.waitN;
  assign waitOe = q.waitOe;
  assign panelPowerControl = q.pwrOut;
  assign memReq = q.mem;
  assign hreadyout = 1'b1; // zero wait states
  assign hrdata = q.hrdata;
  assign hresp = 1'b0; // always okay

endmodule

// File: dv/hbp_host_port_chk.sv
/*
  checker of host port timing.
  assumes a bind from the bench top.
*/
module hbp_host_port_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic hostSelectN,
  input wire logic [15:0] deviceLocationInputs,
  input wire hbp_pkg::hbp_mem_req_t memReq,
  input wire logic memAck,
  input wire logic waitOutN,
  input wire logic deviceDataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // access rules
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ack;
    memReq.req && memAck;
  endsequence
  sequence s_start;
    $rose(memReq.req);
  endsequence
  a_wait_hold: assert property (memReq.req |-> !waitOutN)
    else $error("wait high during request");
  a_wait_end: assert property (s_ack |=> waitOutN && !memReq.req)
    else $error("wait not released");
  a_wait_cause: assert property ($fell(waitOutN) |-> ##[0:10] memReq.req)
    else $error("wait without request");
  a_wait_select: assert property ($fell(waitOutN) |-> !$past(hostSelectN, 3))
    else $error("wait without select");
  a_req_hold: assert property (memReq.req && !memAck |=> $stable(memReq))
    else $error("request changed");
  a_read_drive: assert property (memReq.req && memAck && !memReq.write |=> deviceDataOe)
    else $error("read data not driven");
  a_write_quiet: assert property (memReq.req && memReq.write |-> !deviceDataOe)
    else $error("data driven in write");
  a_sel_first: assert property (s_start |-> !$past(hostSelectN, 3))
    else $error("request without select");
  a_addr_pass: assert property (s_start |-> memReq.addr == $past(deviceLocationInputs, 3))
    else $error("address altered");
endmodule

// File: dv/hbp_host_model.sv
/*
  host side with external decode: free bus clock, select, strobes.
  assumes the bench resolves the wait pin.
*/
module hbp_host_model (
  input wire logic clk,
  output logic hostBusClock,
  output logic hostSelectN,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic highByteEnableN,
  output logic [15:0] deviceLocationInputs,
  output logic [15:0] deviceDataIn,
  input wire logic [15:0] deviceDataOut,
  input wire logic waitOutN
);
  timeunit 1ns;
  timeprecision 1ps;
  // active-high view of wait, as an inverting host sees it
  wire logic waitHi = ~waitOutN;
  int lateCount;
  // ----
  // bus cycles
  // ----
  initial begin
    {hostSelectN, readStrobeN, writeStrobeN, highByteEnableN} = 4'hF;
    {deviceLocationInputs, deviceDataIn} = 32'h0;
    hostBusClock = 1'b0;
    forever #40 hostBusClock = ~hostBusClock;
  end
  // one access; q holds data seen as wait ends
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
    input logic bheN, output logic [15:0] q);
    int n;
    n = 0;
    @(negedge hostBusClock);
    deviceLocationInputs <= a;
    @(negedge hostBusClock);
    hostSelectN <= 1'b0;
    highByteEnableN <= bheN;
    readStrobeN <= wr;
    writeStrobeN <= !wr;
    if (wr) deviceDataIn <= d;
    while (waitHi !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    do begin
      @(posedge hostBusClock);
      n++;
    end while (waitHi !== 1'b0 && n < 900);
    if (waitHi !== 1'b0) lateCount++; // wait never released
    q = deviceDataOut;
    @(negedge hostBusClock);
    {hostSelectN, readStrobeN, writeStrobeN, highByteEnableN} <= 4'hF;
    deviceDataIn <= ~deviceDataIn; // released lines lose stale value
    @(negedge hostBusClock);
  endtask
endmodule

// File: dv/hbp_host_port_tb_top.sv
/*
  bench top: clock, reset, core stand-in, ahb master, scenarios.
  assumes the host model and checker files.
*/
module hbp_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, hsel, hwrite, memAck, byteOrderStrap, panelPowerPolarityStrap;
  logic busStatusStrapN, busySeen, deviceDataOe, waitOutN, waitOe;
  logic panelPowerControl, hreadyout, hresp;
  logic [2:0] busModeStraps, hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q32;
  logic [15:0] memRdata, deviceDataOut, q16;
  wire logic hostBusClock, hostSelectN, readStrobeN, writeStrobeN, highByteEnableN;
  wire logic [15:0] deviceLocationInputs, deviceDataIn;
  wire logic waitPin = waitOe ? waitOutN : 1'b1; // pulled up when released
  wire logic [15:0] readPins = deviceDataOe ? deviceDataOut : ~deviceDataOut; // stale inverse
  hbp_pkg::hbp_mem_req_t memReq, lastReq;
  int fails, testsRun, ackDelay, cnt, cyc;
  // ----
  // structure
  // ----
  hbp_host_port i_hbp_host_port (.clk, .srst, .hostBusClock, .hostSelectN, .readStrobeN,
    .writeStrobeN, .highByteEnableN, .rdWrDirN(1'b1), .busStatusStrapN, .busModeStraps,
    .byteOrderStrap, .panelPowerPolarityStrap, .deviceLocationInputs, .deviceDataIn,
    .deviceDataOut, .deviceDataOe, .waitOutN, .waitOe, .panelPowerControl, .memReq, .memAck,
    .memRdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp);
  hbp_host_model i_hbp_host_model (.clk, .hostBusClock, .hostSelectN, .readStrobeN,
    .writeStrobeN, .highByteEnableN, .deviceLocationInputs, .deviceDataIn,
    .deviceDataOut(readPins), .waitOutN(waitPin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // core arbiter: answers a held request after ackDelay cycles
  always @(posedge clk) begin
    memAck <= 1'b0;
    if (waitOe !== 1'b0 || memReq.req !== 1'b0) busySeen <= 1'b1;
    if (memReq.req === 1'b1 && memAck === 1'b0) begin
      cnt <= cnt + 1;
      if (cnt >= ackDelay) begin
        memAck <= 1'b1;
        cnt <= 0;
        lastReq <= memReq;
      end
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      testDone();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic testDone();
    if (fails == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // straps {mode, status, order, polarity}; held long enough to pass the sync
  task automatic doReset(input logic [5:0] c);
    {busModeStraps, busStatusStrapN, byteOrderStrap, panelPowerPolarityStrap} <= c;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // ----
  // scenarios
  // ----
  task automatic tStraps();
    logic [5:0] cfg [4] = '{6'h3C, 6'h3B, 6'h1E, 6'h29};
    logic m7;
    foreach (cfg[i]) begin
      doReset(cfg[i]);
      m7 = cfg[i][5:3] == 3'h7;
      ahb(1'b0, 32'h4, 32'h0, q32);
      chk(q32, {m7 & ~cfg[i][2], m7 & cfg[i][2], cfg[i][0], cfg[i][1], cfg[i][2],
        cfg[i][5:3]});
      chk(panelPowerControl, !cfg[i][0]);
      chk(hresp, 1'b0);
      ahb(1'b1, 32'h0, 32'h1, q32);
      repeat (4) @(posedge clk);
      chk(panelPowerControl, cfg[i][0]);
    end
  endtask
  task automatic tAccess(input logic o);
    doReset({4'hF, o, 1'b0});
    ackDelay = 2;
    i_hbp_host_model.access(1'b1, 16'h1234, 16'hA55A, 1'b0, q16);
    chk({lastReq.write, lastReq.be, lastReq.addr, lastReq.wdata},
      {3'h7, 16'h1234, o ? 16'h5AA5 : 16'hA55A});
    ackDelay = 40;
    i_hbp_host_model.access(1'b1, 16'h0010, 16'h00C3, 1'b1, q16);
    chk({lastReq.write, lastReq.be, lastReq.addr, lastReq.wdata},
      {1'b1, o ? 2'h2 : 2'h1, 16'h0010, o ? 16'hC300 : 16'h00C3});
    memRdata <= 16'h1357;
    i_hbp_host_model.access(1'b0, 16'h0022, 16'h0000, 1'b0, q16);
    chk({lastReq.write, lastReq.addr, q16},
      {1'b0, 16'h0022, o ? 16'h5713 : 16'h1357});
  endtask
  task automatic tNoServe();
    doReset(6'h1C);
    busySeen <= 1'b0;
    i_hbp_host_model.access(1'b1, 16'h0004, 16'h1111, 1'b0, q16);
    chk(busySeen, 1'b0);
  endtask
  initial begin
    {srst, hsel, hwrite, memAck, busySeen} = 5'h10;
    {htrans, hsize, haddr, hwdata, memRdata} = {2'h0, 3'h2, 80'h0};
    {busModeStraps, busStatusStrapN, byteOrderStrap, panelPowerPolarityStrap} = 6'h3C;
    tStraps();
    tAccess(1'b0);
    tAccess(1'b1);
    tNoServe();
    chk(i_hbp_host_model.lateCount, 40'h0);
    testDone();
  end
endmodule

bind hbp_host_port hbp_host_port_chk i_hbp_host_port_chk (.clk, .srst, .hostSelectN,
  .deviceLocationInputs, .memReq, .memAck, .waitOutN, .deviceDataOe);
